// *** rtl/cic_decim.sv ***
// Purpose: Fifth-order integrator-comb decimator with bypass, output FIFO and
//          AHB-Lite register slave.
// Assumes: Mixer samples arrive on the hclk domain; zero-wait bus answers.
// Notes:   ce low freezes every flip-flop and stretches bus transfers.
// Operation
// (RULE1) The stage takes its samples straight from the oscillator/mixer output.
// (RULE2) One sample is taken per input sample and one leaves per ratio inputs.
// (RULE3) Any integer ratio from 2 to 32 is supported when not bypassed.
// (RULE4) Software writes ratio minus one into a 5-bit field; the block uses it plus one.
// (RULE5) Five integrator and comb sections, delay equal to ratio, gain 2^-(scale+5).
// (RULE6) The scale is an unsigned 0 to 20 applied as a right shift of the result.
// (RULE7) Each scale step attenuates by 6 dB, halving the gain.
// (RULE8) Software should pick the smallest scale that cannot overflow.
// (RULE9) A bypass gives an effective ratio of one.
// (RULE10) While bypassed no scaling is applied.
// (RULE11) While bypassed each input passes unchanged at the input rate.
// (RULE12) The stage takes one sample every clock, so it runs at full port rate; here in_ready drops while the output FIFO has no free slot.
// (RULE13) Each output sample carries a one-cycle valid strobe; here out_valid from the FIFO stays high until out_ready takes the sample.
`timescale 1ns/1ps
`default_nettype none

module cic_fifo #(
  parameter int unsigned WIDTH = 36,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     ce,
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [WIDTH-1:0]              out_data,
  output logic [$clog2(DEPTH):0]        level
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0]    wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [AW:0]      cnt_ff, nxt_cnt;
  logic             push, pop;

  assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem_ff[rd_ff];
  assign level     = cnt_ff;
  assign push      = ce & in_valid & in_ready;
  assign pop       = ce & out_valid & out_ready;

  always_comb begin
    nxt_wr  = push ? ((wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1) : wr_ff;
    nxt_rd  = pop  ? ((rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1) : rd_ff;
    nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else if (ce) begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  // Storage has no reset; contents are never read while empty
  always_ff @(posedge hclk) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data;
    end
  end
endmodule : cic_fifo

module cic_rail
  import cic_pkg::*;
(
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     ce,
  input  wire logic                     acc,
  input  wire logic                     tick,
  input  wire logic signed [SAMP_W-1:0] x,
  input  wire logic [4:0]               shift,
  output logic signed [SAMP_W-1:0]      y
);
  logic signed [ACC_W-1:0] integ_ff [ORDER];
  logic signed [ACC_W-1:0] nxt_integ [ORDER];
  logic signed [ACC_W-1:0] dly_ff [ORDER];
  logic signed [ACC_W-1:0] nxt_dly [ORDER];
  logic signed [ACC_W-1:0] comb [ORDER+1];
  logic signed [ACC_W-1:0] scaled;

  always_comb begin
    comb[0] = integ_ff[ORDER-1];
    for (int k = 0; k < ORDER; k++) begin
      comb[k+1]    = comb[k] - dly_ff[k];
      nxt_integ[k] = integ_ff[k];
      nxt_dly[k]   = tick ? comb[k] : dly_ff[k];
    end
    if (acc) begin
      nxt_integ[0] = integ_ff[0] + ACC_W'(x); // RULE1
      for (int k = 1; k < ORDER; k++) begin
        nxt_integ[k] = integ_ff[k] + integ_ff[k-1]; // RULE5
      end
    end
    // Wraparound arithmetic makes the comb output exact despite integrator overflow
    scaled = comb[ORDER] >>> shift; // RULE5 RULE7
    y      = scaled[SAMP_W-1:0];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int k = 0; k < ORDER; k++) begin
        integ_ff[k] <= '0;
        dly_ff[k]   <= '0;
      end
    end else if (ce) begin
      integ_ff <= nxt_integ;
      dly_ff   <= nxt_dly;
    end
  end
endmodule : cic_rail

module cic_decim (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                ce,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic                     hreadyout,
  output logic                     hresp,
  output logic [31:0]              hrdata,
  input  wire logic                in_valid,
  output logic                     in_ready,
  input  wire cic_pkg::cic_sample_t in_sample,
  output logic                     out_valid,
  input  wire logic                out_ready,
  output cic_pkg::cic_sample_t     out_sample
);
  import cic_pkg::*;
  localparam int unsigned LVL_W = $clog2(FIFO_DEPTH) + 1;
  logic [4:0]  ratio_m1_ff, nxt_ratio_m1;
  logic [4:0]  gain_ff, nxt_gain;
  logic        bypass_ff, nxt_bypass;
  logic        dp_wr_ff, nxt_dp_wr;
  logic [31:0] dp_addr_ff, nxt_dp_addr;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic        addr_take, cfg_change;

  logic [4:0]        phase_ff, nxt_phase;
  cic_sample_t       res_ff, nxt_res;
  logic              resv_ff, nxt_resv;
  logic              acc, tick, fifo_in_ready;
  logic [LVL_W-1:0]  level;
  logic [4:0]        shift;
  logic signed [SAMP_W-1:0] yi, yq;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Bus: zero wait states; ce low inserts wait states instead of dropping transfers
  assign hreadyout = ce;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;
  assign addr_take = ce & hsel & hready & htrans[1];

  always_comb begin
    nxt_dp_wr    = addr_take & hwrite & (hsize == HSIZE_WORD);
    nxt_dp_addr  = addr_take ? haddr : dp_addr_ff;
    nxt_ratio_m1 = ratio_m1_ff;
    nxt_gain     = gain_ff;
    nxt_bypass   = bypass_ff;
    if (dp_wr_ff && dp_addr_ff == OFF_RATIO) begin
      // Ratio 1 only via bypass, so a stored zero is lifted to ratio 2
      nxt_ratio_m1 = (hwdata[4:0] < RATIO_M1_MIN) ? RATIO_M1_MIN : hwdata[4:0]; // RULE3 RULE4
    end
    if (dp_wr_ff && dp_addr_ff == OFF_CTRL) begin
      nxt_bypass = hwdata[CTRL_BYPASS_BIT]; // RULE9
      nxt_gain   = (hwdata[CTRL_GAIN_LSB +: 5] > GAIN_MAX) ? GAIN_MAX
                 : hwdata[CTRL_GAIN_LSB +: 5]; // RULE6
    end
    // Ratio and control reads use next values so a read right after a write sees the new data
    nxt_hrdata = hrdata_ff;
    if (addr_take && !hwrite) begin
      nxt_hrdata = 32'h0000_0000;
      case (haddr)
        OFF_RATIO: nxt_hrdata[4:0] = nxt_ratio_m1; // RULE4
        OFF_CTRL: begin
          nxt_hrdata[CTRL_BYPASS_BIT]    = nxt_bypass;
          nxt_hrdata[CTRL_GAIN_LSB +: 5] = nxt_gain;
        end
        OFF_STAT: begin
          nxt_hrdata[STAT_PHASE_LSB +: 5]     = phase_ff;
          nxt_hrdata[STAT_LEVEL_LSB +: LVL_W] = level;
          nxt_hrdata[STAT_BYPASS_BIT]         = bypass_ff;
        end
        default: nxt_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ratio_m1_ff <= RATIO_M1_RST;
      gain_ff     <= GAIN_RST;
      bypass_ff   <= BYPASS_RST;
      dp_wr_ff    <= 1'b0;
      dp_addr_ff  <= 32'h0000_0000;
      hrdata_ff   <= 32'h0000_0000;
    end else if (ce) begin
      ratio_m1_ff <= nxt_ratio_m1;
      gain_ff     <= nxt_gain;
      bypass_ff   <= nxt_bypass;
      dp_wr_ff    <= nxt_dp_wr;
      dp_addr_ff  <= nxt_dp_addr;
      hrdata_ff   <= nxt_hrdata;
    end
  end

  // Datapath; the slot for a result still in flight is reserved in the FIFO
  assign in_ready   = ce & ((level + LVL_W'(resv_ff)) < LVL_W'(FIFO_DEPTH)); // RULE12
  assign acc        = in_valid & in_ready; // RULE2
  assign tick       = acc & ~bypass_ff & (phase_ff == ratio_m1_ff); // RULE2 RULE4
  assign cfg_change = dp_wr_ff & ((dp_addr_ff == OFF_RATIO) | (dp_addr_ff == OFF_CTRL));
  assign shift      = gain_ff + GAIN_BIAS; // RULE5

  cic_rail u_rail_i (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .acc     (acc & ~bypass_ff),
    .tick    (tick),
    .x       (in_sample.i),
    .shift   (shift),
    .y       (yi)
  );

  cic_rail u_rail_q (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .acc     (acc & ~bypass_ff),
    .tick    (tick),
    .x       (in_sample.q),
    .shift   (shift),
    .y       (yq)
  );

  always_comb begin
    nxt_phase = phase_ff;
    if (cfg_change) begin
      nxt_phase = 5'h00;
    end else if (tick) begin
      nxt_phase = 5'h00;
    end else if (acc && !bypass_ff) begin
      nxt_phase = phase_ff + 5'h01;
    end
    nxt_resv = tick | (acc & bypass_ff); // RULE13
    nxt_res  = res_ff;
    if (acc && bypass_ff) begin
      nxt_res = in_sample; // RULE10 RULE11
    end else if (tick) begin
      nxt_res.i = yi;
      nxt_res.q = yq;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_ff <= 5'h00;
      res_ff   <= '0;
      resv_ff  <= 1'b0;
    end else if (ce) begin
      phase_ff <= nxt_phase;
      res_ff   <= nxt_res;
      resv_ff  <= nxt_resv;
    end
  end

  cic_fifo #(
    .WIDTH ($bits(cic_sample_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .ce        (ce),
    .in_valid  (resv_ff),
    .in_ready  (fifo_in_ready),
    .in_data   (res_ff),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_sample),
    .level     (level)
  );

  sequence s_decim_tick;
    ce && tick;
  endsequence
  sequence s_result_out;
    resv_ff && res_ff.i == $past(yi) && res_ff.q == $past(yq);
  endsequence
  a_bypass_pass_through: assert property (ce && acc && bypass_ff |=> // RULE11
    resv_ff && res_ff == $past(in_sample))
    else $error("bypass did not pass the sample unchanged");
  a_decim_result_out: assert property (s_decim_tick |=> s_result_out) // RULE13
    else $error("decimated result not strobed after tick");
  a_strobe_cause: assert property (ce && resv_ff && $past(ce) |-> // RULE13
    $past(tick || (acc && bypass_ff)))
    else $error("output strobe without a cause");
  a_phase_restart: assert property (s_decim_tick ##1 !cfg_change |-> phase_ff == 5'h00) // RULE2
    else $error("phase did not restart after output");
  a_phase_bound: assert property (!bypass_ff |-> phase_ff <= ratio_m1_ff) // RULE2
    else $error("phase ran past ratio");
  a_ratio_floor: assert property (ratio_m1_ff >= RATIO_M1_MIN) // RULE3
    else $error("ratio below two");
  a_ratio_write: assert property (ce && dp_wr_ff && dp_addr_ff == OFF_RATIO
    && hwdata[4:0] != 5'h00 |=> ratio_m1_ff == $past(hwdata[4:0])) // RULE4
    else $error("ratio write not stored");
  a_gain_limit: assert property (gain_ff <= GAIN_MAX) // RULE6
    else $error("gain shift above limit");
  a_fifo_room: assert property (resv_ff |-> fifo_in_ready) // RULE12
    else $error("result strobe met a full fifo");

endmodule : cic_decim

`default_nettype wire

// *** rtl/cic_pkg.sv ***
// Purpose: Shared constants and types for the fifth-order decimating filter.
// Assumes: One clock, registers on an AHB-Lite slave port.
// Notes:   Offsets are byte addresses of aligned 32-bit words.
package cic_pkg;

  localparam int unsigned SAMP_W     = 18;
  localparam int unsigned ACC_W      = 43;
  localparam int unsigned ORDER      = 5;
  localparam int unsigned FIFO_DEPTH = 8;

  localparam logic [31:0] OFF_RATIO = 32'h0000_0000;
  localparam logic [31:0] OFF_CTRL  = 32'h0000_0004;
  localparam logic [31:0] OFF_STAT  = 32'h0000_0008;

  localparam int unsigned CTRL_BYPASS_BIT = 0;
  localparam int unsigned CTRL_GAIN_LSB   = 8;
  localparam int unsigned STAT_PHASE_LSB  = 0;
  localparam int unsigned STAT_LEVEL_LSB  = 8;
  localparam int unsigned STAT_BYPASS_BIT = 16;

  localparam logic [4:0] RATIO_M1_RST = 5'h03;
  localparam logic [4:0] RATIO_M1_MIN = 5'h01;
  localparam logic [4:0] GAIN_RST     = 5'h00;
  localparam logic [4:0] GAIN_MAX     = 5'h14;
  localparam logic [4:0] GAIN_BIAS    = 5'h05;
  localparam logic       BYPASS_RST   = 1'b0;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  typedef struct packed {
    logic signed [SAMP_W-1:0] i;
    logic signed [SAMP_W-1:0] q;
  } cic_sample_t;

endpackage : cic_pkg

// *** tb/cic_decim_tb_top.sv ***
// Purpose: Self-checking bench for the decimating filter and its registers.
// Assumes: ce high except one stalled read; DC inputs give exact expected outputs.
// Notes:   Last outputs of each filter case only, since integrators keep old history.
`timescale 1ns/1ps
`default_nettype none

module cic_decim_tb_top;
  import cic_pkg::*;
  logic        hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        in_valid, in_ready, out_valid, out_ready, stall, pop;
  cic_sample_t in_sample, out_sample;
  cic_sample_t got[$];
  int          err_total, checks_done, n;
  int          m1s[5] = '{1, 3, 3, 31, 3};
  int          gs[5]  = '{0, 5, 6, 20, 21};
  int          cs[5]  = '{1000, 100, 100, 1000, 131071};

  assign hready = hreadyout;
  always #12.5 hclk = ~hclk;
  always @(posedge hclk) if (pop) got.push_back(out_sample);

  cic_decim uut (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .in_valid, .in_ready, .in_sample, .out_valid,
    .out_ready, .out_sample);
  cic_sink_model sink (.hclk, .stall, .out_valid, .out_ready, .pop);

  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= HSIZE_WORD;
    htrans <= HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic rdchk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk({4'h0, rd & m}, {4'h0, e});
    chk(36'(hresp), 36'h0);
  endtask : rdchk

  // Holds valid and data until taken; gives up after lim edges
  task automatic stream(input int cnt, input int c, input int step, input int lim);
    logic signed [17:0] v;
    v = 18'(c);
    n = 0;
    in_sample <= {v, 18'(-v)};
    in_valid  <= 1'b1;
    for (int k = 0; k < lim && n < cnt; k++) begin
      @(posedge hclk);
      if (in_ready === 1'b1) begin
        n++;
        v = v + 18'(step);
        in_sample <= {v, 18'(-v)};
      end
    end
    in_valid <= 1'b0;
  endtask : stream

  task automatic drain(input int cnt);
    for (int k = 0; k < 400 && got.size() < cnt; k++) @(posedge hclk);
    repeat (20) @(posedge hclk);
    chk(36'(got.size()), 36'(cnt));
  endtask : drain

  function automatic logic [35:0] expect_of(input int c, input int r, input int g);
    longint p;
    p = longint'(c) * r ** 5;
    if (g > 20) g = 20;
    return {18'(p >>> (g + 5)), 18'((-p) >>> (g + 5))};
  endfunction : expect_of

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  initial begin
    #200000;
    err_total++;
    close_out();
  end

  initial begin
    {hclk, hresetn, hsel, hwrite, in_valid, stall} = '0;
    {haddr, hwdata, htrans, hsize, in_sample} = '0;
    {err_total, checks_done} = '0;
    ce = 1'b1;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    rdchk(OFF_RATIO, 32'h1F, {27'h0, RATIO_M1_RST});
    rdchk(OFF_CTRL, 32'hFFFF_FFFF, 32'h0);
    bus(1'b1, OFF_RATIO, 32'h0);
    rdchk(OFF_RATIO, 32'h1F, 32'h1);
    rdchk(32'hC, 32'hFFFF_FFFF, 32'h0);
    // Clock enable low must stretch the transfer, not drop it
    ce <= 1'b0;
    fork
      rdchk(OFF_RATIO, 32'h1F, 32'h1);
      begin
        repeat (4) @(posedge hclk);
        chk(36'(hreadyout), 36'h0);
        ce <= 1'b1;
      end
    join
    $display("registers done");
    for (int k = 0; k < 5; k++) begin
      bus(1'b1, OFF_RATIO, 32'(m1s[k]));
      rdchk(OFF_RATIO, 32'h1F, 32'(m1s[k]));
      bus(1'b1, OFF_CTRL, 32'(gs[k]) << CTRL_GAIN_LSB);
      stall <= k[0];
      got.delete();
      stream(8 * (m1s[k] + 1), cs[k], 0, 4000);
      stall <= 1'b0;
      drain(8);
      chk(got[6], expect_of(cs[k], m1s[k] + 1, gs[k]));
      chk(got[7], expect_of(cs[k], m1s[k] + 1, gs[k]));
    end
    $display("filter cases done");
    bus(1'b1, OFF_CTRL, 32'h0000_1401);
    stall <= 1'b1;
    got.delete();
    stream(12, -20000, 3, 30);
    chk(36'(n), 36'(FIFO_DEPTH));
    rdchk(OFF_STAT, 32'h0001_0F00, 32'h0001_0800);
    stall <= 1'b0;
    drain(8);
    for (int k = 0; k < 8; k++) chk(got[k], {18'(-20000 + 3 * k), 18'(20000 - 3 * k)});
    $display("bypass done");
    close_out();
  end
endmodule : cic_decim_tb_top

`default_nettype wire

// *** tb/cic_sink_model.sv ***
// Purpose: Downstream half-band chain stand-in that takes decimated samples.
// Assumes: Same clock as the filter; stall comes from the bench.
// Notes:   Ready is withheld while stalled so the output FIFO backs up.
`timescale 1ns/1ps
`default_nettype none

module cic_sink_model (
  input  wire logic hclk,
  input  wire logic stall,
  input  wire logic out_valid,
  output logic      out_ready,
  output logic      pop
);
  assign out_ready = ~stall;
  assign pop       = out_valid & out_ready;
endmodule : cic_sink_model

`default_nettype wire
